// [logic/prpd_pkg.sv]
// How it works
// - Mode 001 runs oscillator; reference counter divides unless standby holds it.
// - Active crystal mode in standby keeps oscillator running, reference counter halted.
// - Mode zero stops the oscillator whether or not in standby.
// - Mode seven gives reference output at reference input divided by 16.
// - Mode three passes reference input to reference output one to one.
// - Reset sets reference output to divide by eight.
// - Mode two keeps reference input working, reference output disabled low.
// - Single-ended output sinks when feedback leads, sources when lagging; polarity swaps.
// - Detector select low floats the single-ended output.
// - Standby floats the single-ended output.
// - Feedback phase output pulses low when leading, reference phase output when lagging.
// - Polarity swaps phase outputs; detector select low enables them, standby disables them.
// - Disabled or standby holds both phase outputs high.
// - Lock indicator is the AND of both inverted internal detector outputs, in either detector mode.
// - After reset the lock indicator is disabled and static low.
// - Prescaler divides by 65 with modulus control low, 64 when high.
// - Both current-select bits set give full detector current; others reduced.
// - Detector select high: single-ended on, phase outputs high; low: the reverse.
// - Lock enable high passes lock function; low forces static low.
// - Leaving standby, first feedback pulse reloads reference counter and clears detectors.
`default_nettype none

package prpd_pkg;
    localparam logic [2:0] MODE_XTAL_OFF = 3'h0;
    localparam logic [2:0] MODE_XTAL_ON  = 3'h1;
    localparam logic [2:0] MODE_OUT_OFF  = 3'h2;
    localparam logic [2:0] MODE_DIV1     = 3'h3;
    localparam logic [2:0] MODE_DIV2     = 3'h4;
    localparam logic [2:0] MODE_DIV4     = 3'h5;
    localparam logic [2:0] MODE_DIV8     = 3'h6;
    localparam logic [2:0] MODE_DIV16    = 3'h7;
    localparam logic [2:0] MODE_RESET    = MODE_DIV8;
    localparam int         REF_DIV_W     = 4;
    localparam int         RCNT_W        = 13;
    localparam logic [RCNT_W-1:0] RCNT_ONE = 13'h0001;
    localparam int         OVERLAP_W     = 2;
    localparam logic [OVERLAP_W-1:0] OVERLAP_CYC = 2'h2;
    localparam int         PRE_W         = 7;
    localparam logic [PRE_W-1:0] PRE_DIV_LO = 7'h41;
    localparam logic [PRE_W-1:0] PRE_DIV_HI = 7'h40;
    localparam int         CUR_W         = 7;
    localparam logic [CUR_W-1:0] CUR_FULL = 7'h64;
    localparam logic [CUR_W-1:0] CUR_STEP_FINE   = 7'h0a;
    localparam logic [CUR_W-1:0] CUR_STEP_COARSE = 7'h19;

    typedef enum logic [1:0] {
        PRPD_RUN    = 2'b00,
        PRPD_HOLD   = 2'b01,
        PRPD_REARM  = 2'b11
    } prpd_low_power_hold_e;
endpackage

`default_nettype wire

// [logic/prpd_pfd_if.sv]
`default_nettype none

interface prpd_pfd_if;
    logic ref_edge;
    logic fb_edge;
    logic init;
    logic up;
    logic down;
    modport core (output ref_edge, output fb_edge, output init, input up, input down);
    modport pfd  (input ref_edge, input fb_edge, input init, output up, output down);
endinterface

`default_nettype wire

// [logic/prpd_pfd.sv]
`default_nettype none

module prpd_pfd
    import prpd_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    prpd_pfd_if.pfd   pfd
);
    logic [OVERLAP_W-1:0] overlap;

    // Both set: hold briefly so the pair shows the narrow in-phase pulse
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pfd.up   <= 1'b0;
            pfd.down <= 1'b0;
        end else if (pfd.init || (overlap == OVERLAP_CYC)) begin
            pfd.up   <= 1'b0;
            pfd.down <= 1'b0;
        end else begin
            if (pfd.ref_edge) pfd.up <= 1'b1;
            if (pfd.fb_edge) pfd.down <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overlap <= '0;
        end else if (pfd.up && pfd.down && !pfd.init && overlap != OVERLAP_CYC) begin
            overlap <= overlap + 1'b1;
        end else begin
            overlap <= '0;
        end
    end
endmodule // prpd_pfd

`default_nettype wire

// [logic/prpd_core.sv]
`default_nettype none

module prpd_core
    import prpd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ref_input_i,
    input  wire logic              ref_mode_load_i,
    input  wire logic [2:0]        ref_mode_i,
    input  wire logic [RCNT_W-1:0] ref_count_i,
    input  wire logic              config_load_i,
    input  wire logic              detector_polarity_i,
    input  wire logic              detector_select_i,
    input  wire logic              lock_out_enable_i,
    input  wire logic              low_power_hold_i,
    input  wire logic [1:0]        current_select_i,
    input  wire logic              current_step_i,
    input  wire logic              feedback_divided_pulse_i,
    input  wire logic              modulus_control_i,
    output logic                   ref_output_o,
    output logic                   osc_run_o,
    output logic                   ref_divided_pulse_o,
    output logic                   single_ended_sink_o,
    output logic                   single_ended_source_o,
    output logic                   single_ended_oe_o,
    output logic [CUR_W-1:0]       detector_current_o,
    output logic                   ref_phase_b_o,
    output logic                   fb_phase_b_o,
    output logic                   lock_indicator_o,
    output logic [PRE_W-1:0]       prescale_ratio_o
);
    import prpd_pkg::*;

    logic [2:0]           ref_mode;
    logic                 polarity;
    logic                 sel_single;
    logic                 lock_en;
    logic                 hold;
    logic [1:0]           cur_sel;
    logic                 cur_step;
    logic [1:0]           ref_sync;
    logic [1:0]           fb_sync;
    logic                 ref_last;
    logic                 fb_last;
    logic                 ref_rise;
    logic                 fb_rise;
    logic [REF_DIV_W-1:0] ref_div;
    logic [RCNT_W-1:0]    rcnt;
    logic                 ref_tick;
    logic                 rpulse_last;
    prpd_low_power_hold_e           low_power_hold_state;
    prpd_low_power_hold_e           next_low_power_hold_state;
    logic                 gate_on;
    logic                 up_lead;
    logic                 dn_lead;
    logic                 double_on;
    logic                 next_ref_out;

    prpd_pfd_if pfd_bus ();

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_mode <= MODE_RESET;
        end else if (ref_mode_load_i) begin
            ref_mode <= ref_mode_i;
        end
    end

    // Config bits all power up low, so lock indicator starts disabled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            polarity   <= 1'b0;
            sel_single <= 1'b0;
            lock_en    <= 1'b0;
            hold       <= 1'b0;
            cur_sel    <= 2'h0;
            cur_step   <= 1'b0;
        end else if (config_load_i) begin
            polarity   <= detector_polarity_i;
            sel_single <= detector_select_i;
            lock_en    <= lock_out_enable_i;
            hold       <= low_power_hold_i;
            cur_sel    <= current_select_i;
            cur_step   <= current_step_i;
        end
    end

    // Pin inputs are asynchronous; edges read only the second stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_sync <= 2'h0;
            fb_sync  <= 2'h0;
            ref_last <= 1'b0;
            fb_last  <= 1'b0;
        end else begin
            ref_sync <= {ref_sync[0], ref_input_i};
            fb_sync  <= {fb_sync[0], feedback_divided_pulse_i};
            ref_last <= ref_sync[1];
            fb_last  <= fb_sync[1];
        end
    end

    assign ref_rise = ref_sync[1] && !ref_last;
    assign fb_rise  = fb_sync[1] && !fb_last;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_div <= '0;
        end else if (ref_rise) begin
            ref_div <= ref_div + 1'b1;
        end
    end

    always_comb begin
        next_ref_out = 1'b0;
        case (ref_mode)
            MODE_DIV1:  next_ref_out = ref_sync[1];
            MODE_DIV2:  next_ref_out = ref_div[0];
            MODE_DIV4:  next_ref_out = ref_div[1];
            MODE_DIV8:  next_ref_out = ref_div[2];
            MODE_DIV16: next_ref_out = ref_div[3];
            MODE_OUT_OFF: next_ref_out = 1'b0;
            default:    next_ref_out = 1'b0;
        endcase
    end

    // Ratios above one rely on the programmer keeping the input in range
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_output_o <= 1'b0;
        end else begin
            ref_output_o <= next_ref_out;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_run_o <= 1'b0;
        end else begin
            osc_run_o <= (ref_mode == MODE_XTAL_ON);
        end
    end

    // Standby recovery: detectors wait for the first feedback pulse, which reloads the reference counter
    always_comb begin
        next_low_power_hold_state = low_power_hold_state;
        case (low_power_hold_state)
            PRPD_RUN:   if (hold) next_low_power_hold_state = PRPD_HOLD;
            PRPD_HOLD:  if (!hold) next_low_power_hold_state = PRPD_REARM;
            PRPD_REARM: begin
                if (hold) next_low_power_hold_state = PRPD_HOLD;
                else if (fb_rise) next_low_power_hold_state = PRPD_RUN;
            end
            default:    next_low_power_hold_state = PRPD_RUN;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_power_hold_state <= PRPD_RUN;
        end else begin
            low_power_hold_state <= next_low_power_hold_state;
        end
    end

    assign gate_on = (low_power_hold_state == PRPD_RUN);

    // Reference counter counts reference input edges in every mode except mode zero, and halts in standby
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rcnt     <= RCNT_ONE;
            ref_tick <= 1'b0;
        end else if (low_power_hold_state == PRPD_REARM && fb_rise) begin
            rcnt     <= ref_count_i;
            ref_tick <= 1'b0;
        end else if (hold || ref_mode == MODE_XTAL_OFF) begin
            ref_tick <= 1'b0;
        end else if (ref_rise) begin
            if (rcnt <= RCNT_ONE) begin
                rcnt     <= ref_count_i;
                ref_tick <= 1'b1;
            end else begin
                rcnt     <= rcnt - 1'b1;
                ref_tick <= 1'b0;
            end
        end else begin
            ref_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rpulse_last         <= 1'b0;
            ref_divided_pulse_o <= 1'b0;
        end else begin
            rpulse_last         <= ref_tick;
            ref_divided_pulse_o <= ref_tick;
        end
    end

    assign pfd_bus.ref_edge = gate_on && ref_tick && !rpulse_last;
    assign pfd_bus.fb_edge  = gate_on && fb_rise;
    assign pfd_bus.init     = !gate_on;

    prpd_pfd u_pfd (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pfd     (pfd_bus)
    );

    // up: reference leads (feedback lags); dn: feedback leads
    assign up_lead   = pfd_bus.up && !pfd_bus.down;
    assign dn_lead   = pfd_bus.down && !pfd_bus.up;
    assign double_on = !sel_single && !hold;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            single_ended_sink_o   <= 1'b0;
            single_ended_source_o <= 1'b0;
            single_ended_oe_o     <= 1'b0;
        end else if (!sel_single || hold) begin
            single_ended_sink_o   <= 1'b0;
            single_ended_source_o <= 1'b0;
            single_ended_oe_o     <= 1'b0;
        end else begin
            single_ended_sink_o   <= polarity ? up_lead : dn_lead;
            single_ended_source_o <= polarity ? dn_lead : up_lead;
            single_ended_oe_o     <= up_lead || dn_lead;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_phase_b_o <= 1'b1;
            fb_phase_b_o  <= 1'b1;
        end else if (!double_on) begin
            ref_phase_b_o <= 1'b1;
            fb_phase_b_o  <= 1'b1;
        end else begin
            fb_phase_b_o  <= !(polarity ? pfd_bus.up : pfd_bus.down);
            ref_phase_b_o <= !(polarity ? pfd_bus.down : pfd_bus.up);
        end
    end

    // Lock follows the internal detector so it stays live in either detector mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_indicator_o <= 1'b0;
        end else if (!lock_en) begin
            lock_indicator_o <= 1'b0;
        end else if (hold) begin
            lock_indicator_o <= 1'b1;
        end else begin
            lock_indicator_o <= !pfd_bus.up && !pfd_bus.down;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            detector_current_o <= CUR_FULL;
        end else if (&cur_sel) begin
            detector_current_o <= CUR_FULL;
        end else begin
            // Inverted select counts the steps below full; concatenation zero-extends it to seven bits wide
            detector_current_o <= CUR_FULL - (cur_step ? CUR_STEP_COARSE : CUR_STEP_FINE)
                                  * {{(CUR_W - $bits(cur_sel)){1'b0}}, ~cur_sel};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prescale_ratio_o <= PRE_DIV_LO;
        end else begin
            prescale_ratio_o <= modulus_control_i ? PRE_DIV_HI : PRE_DIV_LO;
        end
    end
endmodule // prpd_core

`default_nettype wire

// [sim/prpd_core_monitor.sv]
`default_nettype none

module prpd_core_monitor
    import prpd_pkg::*;
(
    input wire logic                       clk_i,
    input wire logic                       rst_b_i,
    input wire logic                       modulus_control_i,
    input wire logic                       ref_divided_pulse_o,
    input wire logic                       single_ended_sink_o,
    input wire logic                       single_ended_oe_o,
    input wire logic [prpd_pkg::CUR_W-1:0] detector_current_o,
    input wire logic                       ref_phase_b_o,
    input wire logic                       fb_phase_b_o,
    input wire logic                       lock_indicator_o,
    input wire logic [prpd_pkg::PRE_W-1:0] prescale_ratio_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import prpd_pkg::*;

    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Both outputs come from the same registered select, so no settling slack is needed
    float_phase_a: assert property (single_ended_oe_o |-> ref_phase_b_o && fb_phase_b_o)
        else $error("phase outputs low while single-ended output drives");
    ratio_hi_a: assert property (modulus_control_i [*4] |-> prescale_ratio_o == PRE_DIV_HI)
        else $error("prescaler ratio not 64 with modulus high");
    ratio_lo_a: assert property (!modulus_control_i [*4] |-> prescale_ratio_o == PRE_DIV_LO)
        else $error("prescaler ratio not 65 with modulus low");
    overlap_clear_a: assert property (!ref_phase_b_o && !fb_phase_b_o |-> ##[1:4] ref_phase_b_o && fb_phase_b_o)
        else $error("detector overlap not cleared");
    lock_follow_a: assert property ($fell(fb_phase_b_o) || $fell(ref_phase_b_o) |-> ##[0:2] !lock_indicator_o)
        else $error("lock high while a phase output is low");
    reset_lock_a: assert property ($rose(rst_b_i) |-> !lock_indicator_o)
        else $error("lock high after reset");
    ref_pulse_a: assert property (ref_divided_pulse_o |=> !ref_divided_pulse_o)
        else $error("divided reference pulse longer than one cycle");
    current_set_a: assert property (detector_current_o inside {7'h64, 7'h5a, 7'h50, 7'h46, 7'h4b, 7'h32, 7'h19})
        else $error("detector current outside the table");

    cover property (single_ended_sink_o);
    cover property (!fb_phase_b_o);
    cover property (ref_divided_pulse_o);
endmodule // prpd_core_monitor

`default_nettype wire

// [sim/prpd_vco_model.sv]
`default_nettype none

module prpd_vco_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] period_i,
    output var  logic       fb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;

    initial fb_o = 1'b0;
    // Period zero means the loop is idle: line rests low
    always @(negedge clk_i) begin
        if (period_i == 8'h00) begin
            cnt <= 8'h00;
            fb_o <= 1'b0;
        end else begin
            cnt <= (cnt + 8'h01 >= period_i) ? 8'h00 : cnt + 8'h01;
            fb_o <= (cnt < 8'h02);
        end
    end
endmodule // prpd_vco_model

`default_nettype wire

// [sim/prpd_core_tb.sv]
`default_nettype none

module prpd_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import prpd_pkg::*;

    logic clk_i = 1'b0, rst_b_i = 1'b0, ref_input_i = 1'b0, ref_mode_load_i = 1'b0, config_load_i = 1'b0;
    logic detector_polarity_i = 1'b0, detector_select_i = 1'b0, lock_out_enable_i = 1'b0, low_power_hold_i = 1'b0;
    logic current_step_i = 1'b0, modulus_control_i = 1'b0, feedback_divided_pulse_i;
    logic [1:0] current_select_i = 2'h3;
    logic [2:0] ref_mode_i = 3'h6;
    logic [RCNT_W-1:0] ref_count_i = 13'h0002;
    logic ref_output_o, osc_run_o, ref_divided_pulse_o, single_ended_sink_o, single_ended_source_o;
    logic single_ended_oe_o, ref_phase_b_o, fb_phase_b_o, lock_indicator_o;
    logic [CUR_W-1:0] detector_current_o;
    logic [PRE_W-1:0] prescale_ratio_o;
    logic [7:0] fb_period = 8'h00;
    int miscompares = 0, num_checks = 0, n;
    int c [8];

    prpd_core DUT (
        .clk_i                    (clk_i),
        .rst_b_i                  (rst_b_i),
        .ref_input_i              (ref_input_i),
        .ref_mode_load_i          (ref_mode_load_i),
        .ref_mode_i               (ref_mode_i),
        .ref_count_i              (ref_count_i),
        .config_load_i            (config_load_i),
        .detector_polarity_i      (detector_polarity_i),
        .detector_select_i        (detector_select_i),
        .lock_out_enable_i        (lock_out_enable_i),
        .low_power_hold_i         (low_power_hold_i),
        .current_select_i         (current_select_i),
        .current_step_i           (current_step_i),
        .feedback_divided_pulse_i (feedback_divided_pulse_i),
        .modulus_control_i        (modulus_control_i),
        .ref_output_o             (ref_output_o),
        .osc_run_o                (osc_run_o),
        .ref_divided_pulse_o      (ref_divided_pulse_o),
        .single_ended_sink_o      (single_ended_sink_o),
        .single_ended_source_o    (single_ended_source_o),
        .single_ended_oe_o        (single_ended_oe_o),
        .detector_current_o       (detector_current_o),
        .ref_phase_b_o            (ref_phase_b_o),
        .fb_phase_b_o             (fb_phase_b_o),
        .lock_indicator_o         (lock_indicator_o),
        .prescale_ratio_o         (prescale_ratio_o)
    );
    prpd_vco_model u_vco (.clk_i(clk_i), .period_i(fb_period), .fb_o(feedback_divided_pulse_i));

    always #25 clk_i = ~clk_i;
    // Reference at 5 MHz, well under the one-to-one limit
    always begin
        repeat (2) @(negedge clk_i);
        ref_input_i = ~ref_input_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task setm(input logic [2:0] m);
        @(negedge clk_i);
        ref_mode_i = m;
        ref_mode_load_i = 1'b1;
        @(negedge clk_i);
        ref_mode_load_i = 1'b0;
        repeat (40) @(negedge clk_i);
    endtask

    task cfg(input logic detector_polarity, sel, len, hold, input logic [1:0] cur, input logic step);
        @(negedge clk_i);
        {detector_polarity_i, detector_select_i, lock_out_enable_i, low_power_hold_i} = {detector_polarity, sel, len, hold};
        {current_select_i, current_step_i} = {cur, step};
        config_load_i = 1'b1;
        @(negedge clk_i);
        config_load_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    // Counts: out high, ref pulse, sink, source, oe, fb low, ref low, lock high
    task watch(input int cyc);
        c = '{default: 0};
        repeat (cyc) begin
            @(negedge clk_i);
            c[0] += ref_output_o;
            c[1] += ref_divided_pulse_o;
            c[2] += single_ended_sink_o;
            c[3] += single_ended_source_o;
            c[4] += single_ended_oe_o;
            c[5] += !fb_phase_b_o;
            c[6] += !ref_phase_b_o;
            c[7] += lock_indicator_o;
        end
    endtask

    // Cycles between two rising edges of the reference output
    task meas(output int per);
        int t0;
        logic p;
        t0 = -1;
        per = 0;
        p = ref_output_o;
        for (int i = 0; i < 400 && per == 0; i++) begin
            @(negedge clk_i);
            if (ref_output_o === 1'b1 && p === 1'b0) begin
                if (t0 >= 0)
                    per = i - t0;
                t0 = i;
            end
            p = ref_output_o;
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        chk(lock_indicator_o, 1'b0);
        chk({ref_phase_b_o, fb_phase_b_o, single_ended_oe_o}, 3'b110);
        chk(prescale_ratio_o, PRE_DIV_LO);
        meas(n);
        chk(n, 32);
        modulus_control_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(prescale_ratio_o, PRE_DIV_HI);
        modulus_control_i = 1'b0;
        $display("test reset and prescaler done");
        for (int m = 3; m < 8; m++) begin
            setm(m[2:0]);
            meas(n);
            chk(n, 4 << (m - 3));
        end
        setm(MODE_OUT_OFF);
        watch(100);
        chk(c[0], 0);
        chk(c[1] > 0, 1);
        setm(MODE_XTAL_ON);
        watch(100);
        chk(osc_run_o, 1'b1);
        chk(c[1] > 0, 1);
        fb_period = 8'h06;
        cfg(1'b0, 1'b1, 1'b1, 1'b1, 2'h3, 1'b0);
        watch(100);
        chk(osc_run_o, 1'b1);
        chk(c[1], 0);
        chk(c[4], 0);
        chk(c[5] + c[6], 0);
        chk(c[7], 100);
        setm(MODE_XTAL_OFF);
        chk(osc_run_o, 1'b0);
        cfg(1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 1'b0);
        watch(100);
        chk(osc_run_o, 1'b0);
        chk(c[1], 0);
        $display("test reference modes done");
        setm(MODE_DIV8);
        // Table: polarity, select, feedback period; ref pulse period is 8
        for (int t = 0; t < 5; t++) begin
            logic [2:0] pc;
            pc = (t == 1) ? 3'b110 : (t == 3) ? 3'b000 : (t == 4) ? 3'b100 : 3'b010;
            fb_period = (t == 2) ? 8'h0c : 8'h06;
            cfg(pc[2], pc[1], t == 3, 1'b0, 2'h3, 1'b0);
            repeat (20) @(negedge clk_i);
            watch(300);
            if (pc[1]) begin
                chk((c[2] > c[3]) != (pc[2] ^ (t == 2)), 1);
                chk(c[5] + c[6], 0);
            end else begin
                chk((c[5] > c[6]) != pc[2], 1);
                chk(c[4], 0);
                chk(t == 3 ? (c[7] > 0 && c[7] < 300) : (c[7] == 0), 1);
            end
        end
        // Feedback idle across standby exit: detectors must stay blocked until it returns
        fb_period = 8'h00;
        cfg(1'b0, 1'b0, 1'b1, 1'b1, 2'h3, 1'b0);
        cfg(1'b0, 1'b0, 1'b1, 1'b0, 2'h3, 1'b0);
        watch(100);
        chk(c[5] + c[6], 0);
        chk(c[1] > 0, 1);
        fb_period = 8'h06;
        watch(100);
        chk(c[5] > 0, 1);
        $display("test detectors done");
        for (int k = 0; k < 8; k++) begin
            cfg(1'b0, 1'b1, 1'b0, 1'b0, k[1:0], k[2]);
            chk(detector_current_o, 100 - (k[2] ? 25 : 10) * (3 - k[1:0]));
        end
        $display("test current done");
        @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        chk(lock_indicator_o, 1'b0);
        $display("test second reset done");
        test_done();
    end
endmodule // prpd_core_tb

bind prpd_core prpd_core_monitor u_mon (
    .clk_i               (clk_i),
    .rst_b_i             (rst_b_i),
    .modulus_control_i   (modulus_control_i),
    .ref_divided_pulse_o (ref_divided_pulse_o),
    .single_ended_sink_o (single_ended_sink_o),
    .single_ended_oe_o   (single_ended_oe_o),
    .detector_current_o  (detector_current_o),
    .ref_phase_b_o       (ref_phase_b_o),
    .fb_phase_b_o        (fb_phase_b_o),
    .lock_indicator_o    (lock_indicator_o),
    .prescale_ratio_o    (prescale_ratio_o)
);

`default_nettype wire
